// [ppu_top.sv]
// Purpose: 32-pin programmable i/o unit with an AXI4-Lite register slave
// Assumes: single clock, software holds data constant for open drain
// Notes:   write acts one edge after address and data are both held
// Function
// - mode and direction bits pick normal, pulled input, output, bare input.
// - at reset each pin is normal function or pulled input.
// - pins idling as active-high outputs pull down, others pull up.
// - high mode register at index 76h resets to zero, pins 31..16.
// - low mode register at index 70h resets to zero, pins 15..0.
// - direction one means input, zero means output or normal function.
// - high direction register at index 78h resets to FFFFh, pins 31..16.
// - low direction register at index 72h resets to FC0Fh, pins 15..0.
// - same bit position in mode, direction, data means same pin.
// - output pins drive their data bit without inversion.
// - input pins read back the external level without inversion.
// - high data register at index 7Ah, pins 31..16, reset value undefined.
// - low data register at index 74h, pins 15..0, reset value undefined.
// - a claimed pin disconnects its normal peripheral function.
// - upper address pins come up in normal function after reset.
`timescale 1ns/1ps
`include "ppu_cfg.svh"
module ppu_top
    import ppu_pkg::*;
#(
    parameter logic [31:0] PULL_DOWN_MASK = `PPU_PULL_DOWN_MASK
)(
    input  wire logic                    CORE_CLK_IN,
    input  wire logic                    RST_IN,
    input  wire logic [`PPU_AXI_AW-1:0]  S_AXI_AWADDR_IN,
    input  wire logic                    S_AXI_AWVALID_IN,
    output logic                         S_AXI_AWREADY_OUT,
    input  wire logic [31:0]             S_AXI_WDATA_IN,
    input  wire logic [3:0]              S_AXI_WSTRB_IN,
    input  wire logic                    S_AXI_WVALID_IN,
    output logic                         S_AXI_WREADY_OUT,
    output logic [1:0]                   S_AXI_BRESP_OUT,
    output logic                         S_AXI_BVALID_OUT,
    input  wire logic                    S_AXI_BREADY_IN,
    input  wire logic [`PPU_AXI_AW-1:0]  S_AXI_ARADDR_IN,
    input  wire logic                    S_AXI_ARVALID_IN,
    output logic                         S_AXI_ARREADY_OUT,
    output logic [31:0]                  S_AXI_RDATA_OUT,
    output logic [1:0]                   S_AXI_RRESP_OUT,
    output logic                         S_AXI_RVALID_OUT,
    input  wire logic                    S_AXI_RREADY_IN,
    input  wire ppu_pkg::ppu_pins_t      PIN_LEVEL_IN,
    output ppu_pkg::ppu_pins_t           PIN_DRIVE_OUT,
    output ppu_pkg::ppu_pins_t           PIN_OE_OUT,
    output ppu_pkg::ppu_pins_t           PIN_PULL_UP_OUT,
    output ppu_pkg::ppu_pins_t           PIN_PULL_DOWN_OUT,
    input  wire ppu_pkg::ppu_pins_t      FUNC_OUT_IN,
    input  wire ppu_pkg::ppu_pins_t      FUNC_OE_IN,
    output ppu_pkg::ppu_pins_t           FUNC_SEL_OUT,
    output ppu_pkg::ppu_pins_t           FUNC_LEVEL_OUT
);
    import ppu_pkg::*;

    ppu_pin_if pin_bus ();

    ppu_half_t      mode_lo_r, dir_lo_r, data_lo_r;
    ppu_half_t      mode_hi_r, dir_hi_r, data_hi_r;
    ppu_half_t      mode_lo_nxt, dir_lo_nxt, data_lo_nxt;
    ppu_half_t      mode_hi_nxt, dir_hi_nxt, data_hi_nxt;
    ppu_wstate_t    wstate_r, wstate_nxt;
    logic           aw_have_r, aw_have_nxt;
    logic           w_have_r, w_have_nxt;
    logic [`PPU_AXI_AW-1:0] awaddr_r, awaddr_nxt;
    ppu_half_t      wdata_r, wdata_nxt;
    logic [1:0]     wstrb_r, wstrb_nxt;
    logic [1:0]     bresp_r, bresp_nxt;
    logic           rvalid_r, rvalid_nxt;
    logic [31:0]    rdata_r, rdata_nxt;
    logic [1:0]     rresp_r, rresp_nxt;
    logic           wr_do;
    logic           first_r;
    ppu_reg_t       wsel, rsel;
    ppu_pins_t      out_mask;
    ppu_pins_t      level_view;

    function automatic ppu_reg_t reg_sel(input logic [`PPU_AXI_AW-1:0] a);
        case (a)
            `PPU_BYTE_ADDR(`PPU_IDX_MODE_LO): reg_sel = PPU_R_MODE_LO;
            `PPU_BYTE_ADDR(`PPU_IDX_DIR_LO):  reg_sel = PPU_R_DIR_LO;
            `PPU_BYTE_ADDR(`PPU_IDX_DATA_LO): reg_sel = PPU_R_DATA_LO;
            `PPU_BYTE_ADDR(`PPU_IDX_MODE_HI): reg_sel = PPU_R_MODE_HI;
            `PPU_BYTE_ADDR(`PPU_IDX_DIR_HI):  reg_sel = PPU_R_DIR_HI;
            `PPU_BYTE_ADDR(`PPU_IDX_DATA_HI): reg_sel = PPU_R_DATA_HI;
            default:                          reg_sel = PPU_R_NONE;
        endcase
    endfunction

    function automatic ppu_half_t merge(input ppu_half_t old,
                                        input ppu_half_t val,
                                        input logic [1:0] strb);
        merge = old;
        if (strb[0])
            merge[7:0] = val[7:0];
        if (strb[1])
            merge[15:8] = val[15:8];
    endfunction

    // same bit index in every register pair names the same pin
    assign pin_bus.mode = {mode_hi_r, mode_lo_r};
    assign pin_bus.dir  = {dir_hi_r, dir_lo_r};
    assign pin_bus.data = {data_hi_r, data_lo_r};

    // output pins read their stored bit, all others the synced pin
    assign out_mask   = pin_bus.mode & ~pin_bus.dir;
    assign level_view = (out_mask & pin_bus.data) |
                        (~out_mask & pin_bus.level);

    ppu_pin_cell #(
        .PULL_DOWN_MASK (PULL_DOWN_MASK)
    ) u_cell (
        .clk_in         (CORE_CLK_IN),
        .rst_in         (RST_IN),
        .pin_bus        (pin_bus),
        .pin_level_in   (PIN_LEVEL_IN),
        .func_out_in    (FUNC_OUT_IN),
        .func_oe_in     (FUNC_OE_IN),
        .pin_drive_out  (PIN_DRIVE_OUT),
        .pin_oe_out     (PIN_OE_OUT),
        .pull_up_out    (PIN_PULL_UP_OUT),
        .pull_down_out  (PIN_PULL_DOWN_OUT),
        .func_sel_out   (FUNC_SEL_OUT),
        .func_level_out (FUNC_LEVEL_OUT)
    );

    assign S_AXI_AWREADY_OUT = ~aw_have_r && (wstate_r == PPU_W_IDLE);
    assign S_AXI_WREADY_OUT  = ~w_have_r && (wstate_r == PPU_W_IDLE);
    assign S_AXI_BVALID_OUT  = (wstate_r == PPU_W_RESP);
    assign S_AXI_BRESP_OUT   = bresp_r;
    assign S_AXI_ARREADY_OUT = ~rvalid_r;
    assign S_AXI_RVALID_OUT  = rvalid_r;
    assign S_AXI_RDATA_OUT   = rdata_r;
    assign S_AXI_RRESP_OUT   = rresp_r;

    assign wr_do = aw_have_r && w_have_r;
    assign wsel  = reg_sel(awaddr_r);
    assign rsel  = reg_sel(S_AXI_ARADDR_IN);

    // address and data may arrive in either order; both are held first
    always_comb
    begin
        wstate_nxt  = wstate_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bresp_nxt   = bresp_r;
        mode_lo_nxt = mode_lo_r;
        dir_lo_nxt  = dir_lo_r;
        data_lo_nxt = data_lo_r;
        mode_hi_nxt = mode_hi_r;
        dir_hi_nxt  = dir_hi_r;
        data_hi_nxt = data_hi_r;
        case (wstate_r)
            PPU_W_IDLE:
            begin
                if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
                begin
                    aw_have_nxt = 1'b1;
                    awaddr_nxt  = S_AXI_AWADDR_IN;
                end
                if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
                begin
                    w_have_nxt = 1'b1;
                    wdata_nxt  = S_AXI_WDATA_IN[15:0];
                    wstrb_nxt  = S_AXI_WSTRB_IN[1:0];
                end
                if (wr_do)
                begin
                    aw_have_nxt = 1'b0;
                    w_have_nxt  = 1'b0;
                    wstate_nxt  = PPU_W_RESP;
                    bresp_nxt   = `PPU_RESP_OKAY;
                    case (wsel)
                        PPU_R_MODE_LO:
                            mode_lo_nxt = merge(mode_lo_r, wdata_r, wstrb_r);
                        PPU_R_DIR_LO:
                            dir_lo_nxt = merge(dir_lo_r, wdata_r, wstrb_r);
                        PPU_R_DATA_LO:
                            data_lo_nxt = merge(data_lo_r, wdata_r, wstrb_r);
                        PPU_R_MODE_HI:
                            mode_hi_nxt = merge(mode_hi_r, wdata_r, wstrb_r);
                        PPU_R_DIR_HI:
                            dir_hi_nxt = merge(dir_hi_r, wdata_r, wstrb_r);
                        PPU_R_DATA_HI:
                            data_hi_nxt = merge(data_hi_r, wdata_r, wstrb_r);
                        default:
                            bresp_nxt = `PPU_RESP_SLVERR;
                    endcase
                end
            end
            PPU_W_RESP:
            begin
                if (S_AXI_BREADY_IN)
                    wstate_nxt = PPU_W_IDLE;
            end
            default:
                wstate_nxt = PPU_W_IDLE;
        endcase
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && S_AXI_RREADY_IN)
            rvalid_nxt = 1'b0;
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `PPU_RESP_OKAY;
            case (rsel)
                PPU_R_MODE_LO: rdata_nxt = {16'h0000, mode_lo_r};
                PPU_R_DIR_LO:  rdata_nxt = {16'h0000, dir_lo_r};
                PPU_R_DATA_LO: rdata_nxt = {16'h0000, level_view[15:0]};
                PPU_R_MODE_HI: rdata_nxt = {16'h0000, mode_hi_r};
                PPU_R_DIR_HI:  rdata_nxt = {16'h0000, dir_hi_r};
                PPU_R_DATA_HI: rdata_nxt = {16'h0000, level_view[31:16]};
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `PPU_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            // address pins 7..9 reset to normal so fetch can start
            mode_lo_r <= `PPU_RST_MODE_LO;
            dir_lo_r  <= `PPU_RST_DIR_LO;
            mode_hi_r <= `PPU_RST_MODE_HI;
            dir_hi_r  <= `PPU_RST_DIR_HI;
            // data is unspecified after reset; zero is one legal choice
            data_lo_r <= `PPU_RST_DATA;
            data_hi_r <= `PPU_RST_DATA;
            wstate_r  <= PPU_W_IDLE;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= {`PPU_AXI_AW{1'b0}};
            wdata_r   <= 16'h0000;
            wstrb_r   <= 2'h0;
            bresp_r   <= `PPU_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `PPU_RESP_OKAY;
            first_r   <= 1'b1;
        end
        else
        begin
            mode_lo_r <= mode_lo_nxt;
            dir_lo_r  <= dir_lo_nxt;
            mode_hi_r <= mode_hi_nxt;
            dir_hi_r  <= dir_hi_nxt;
            data_lo_r <= data_lo_nxt;
            data_hi_r <= data_hi_nxt;
            wstate_r  <= wstate_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            first_r   <= 1'b0;
        end
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_reset_values: assert property (first_r |->
        {mode_hi_r, mode_lo_r} == 32'h0000_0000 &&
        {dir_hi_r, dir_lo_r} == 32'hFFFF_FC0F)
        else $error("mode or direction wrong after reset");
    a_boot_pins_normal: assert property (first_r |->
        FUNC_SEL_OUT[9:7] == 3'h7)
        else $error("upper address pins not in normal function");
    a_write_applies: assert property (
        wr_do && wsel == PPU_R_MODE_LO && wstrb_r == 2'h3
        |=> mode_lo_r == $past(wdata_r) && S_AXI_BVALID_OUT)
        else $error("mode write not applied on next cycle");
    a_read_direction: assert property (
        S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && rsel == PPU_R_DIR_HI
        |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT[15:0] == $past(dir_hi_r))
        else $error("direction read does not return stored value");
    a_resp_held: assert property (
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT &&
        $stable(S_AXI_BRESP_OUT))
        else $error("write response dropped before taken");

    c_write_done: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
    c_read_done: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
    c_bad_addr: cover property (S_AXI_BVALID_OUT && bresp_r[1]);
endmodule

// [ppu_cfg.svh]
// Purpose: offsets, reset values and bus codes of the pin unit
// Assumes: offsets are register indices, byte address is four times that
// Notes:   definitions only
`ifndef PPU_CFG_SVH
`define PPU_CFG_SVH

`define PPU_AXI_AW          12
`define PPU_BYTE_ADDR(idx)  ((idx) << 2)

`define PPU_IDX_MODE_LO     12'h070
`define PPU_IDX_DIR_LO      12'h072
`define PPU_IDX_DATA_LO     12'h074
`define PPU_IDX_MODE_HI     12'h076
`define PPU_IDX_DIR_HI      12'h078
`define PPU_IDX_DATA_HI     12'h07A

`define PPU_RST_MODE_LO     16'h0000
`define PPU_RST_DIR_LO      16'hFC0F
`define PPU_RST_MODE_HI     16'h0000
`define PPU_RST_DIR_HI      16'hFFFF
`define PPU_RST_DATA        16'h0000

`define PPU_PULL_DOWN_MASK  32'h0000_0402

`define PPU_RESP_OKAY       2'h0
`define PPU_RESP_SLVERR     2'h2

`endif

// [ppu_pkg.sv]
// Purpose: types shared by the pin unit modules
// Assumes: nothing
// Notes:   constants live in ppu_cfg.svh
package ppu_pkg;
    typedef logic [31:0] ppu_pins_t;
    typedef logic [15:0] ppu_half_t;

    typedef enum {PPU_CFG_NORMAL, PPU_CFG_IN_PULL, PPU_CFG_OUT,
                  PPU_CFG_IN_FLOAT} ppu_pin_cfg_t;

    typedef enum {PPU_R_MODE_LO, PPU_R_DIR_LO, PPU_R_DATA_LO,
                  PPU_R_MODE_HI, PPU_R_DIR_HI, PPU_R_DATA_HI,
                  PPU_R_NONE} ppu_reg_t;

    typedef enum {PPU_W_IDLE, PPU_W_RESP} ppu_wstate_t;
endpackage

// [ppu_pin_if.sv]
// Purpose: carries pin settings to the pad logic and levels back
// Assumes: one clock domain
// Notes:   bit n of every field belongs to pin n
`timescale 1ns/1ps
interface ppu_pin_if;
    logic [31:0] mode;
    logic [31:0] dir;
    logic [31:0] data;
    logic [31:0] level;

    modport regs (output mode, output dir, output data, input level);
    modport pins (input mode, input dir, input data, output level);
endinterface

// [ppu_pin_cell.sv]
// Purpose: per-pin function select, pulls and input synchroniser
// Assumes: pin levels are asynchronous to the core clock
// Notes:   pad wire level is resolved outside from the enables
`timescale 1ns/1ps
`include "ppu_cfg.svh"
module ppu_pin_cell
    import ppu_pkg::*;
#(
    parameter logic [31:0] PULL_DOWN_MASK = `PPU_PULL_DOWN_MASK
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    ppu_pin_if.pins          pin_bus,
    input  wire ppu_pins_t   pin_level_in,
    input  wire ppu_pins_t   func_out_in,
    input  wire ppu_pins_t   func_oe_in,
    output ppu_pins_t        pin_drive_out,
    output ppu_pins_t        pin_oe_out,
    output ppu_pins_t        pull_up_out,
    output ppu_pins_t        pull_down_out,
    output ppu_pins_t        func_sel_out,
    output ppu_pins_t        func_level_out
);
    ppu_pins_t sync1_r, sync2_r, sync3_r, level_r;
    ppu_pins_t sync1_nxt, sync2_nxt, sync3_nxt, level_nxt;

    function automatic ppu_pin_cfg_t pin_cfg(input logic m, input logic d);
        case ({m, d})
            2'h0: pin_cfg = PPU_CFG_NORMAL;
            2'h1: pin_cfg = PPU_CFG_IN_PULL;
            2'h2: pin_cfg = PPU_CFG_OUT;
            default: pin_cfg = PPU_CFG_IN_FLOAT;
        endcase
    endfunction

    // level follows only once stages two and three agree
    always_comb
    begin
        sync1_nxt = pin_level_in;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
        level_nxt = ((sync2_r ~^ sync3_r) & sync3_r) |
                    ((sync2_r ^ sync3_r) & level_r);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_r <= 32'h0000_0000;
            sync2_r <= 32'h0000_0000;
            sync3_r <= 32'h0000_0000;
            level_r <= 32'h0000_0000;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
            level_r <= level_nxt;
        end
    end

    assign pin_bus.level = level_r;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_pin
            always_comb
            begin
                pin_drive_out[gi]  = 1'b0;
                pin_oe_out[gi]     = 1'b0;
                pull_up_out[gi]    = 1'b0;
                pull_down_out[gi]  = 1'b0;
                func_sel_out[gi]   = 1'b0;
                case (pin_cfg(pin_bus.mode[gi], pin_bus.dir[gi]))
                    PPU_CFG_NORMAL:
                    begin
                        func_sel_out[gi]  = 1'b1;
                        pin_drive_out[gi] = func_out_in[gi];
                        pin_oe_out[gi]    = func_oe_in[gi];
                    end
                    PPU_CFG_IN_PULL:
                    begin
                        pull_up_out[gi]   = ~PULL_DOWN_MASK[gi];
                        pull_down_out[gi] = PULL_DOWN_MASK[gi];
                    end
                    PPU_CFG_OUT:
                    begin
                        pin_drive_out[gi] = pin_bus.data[gi];
                        pin_oe_out[gi]    = 1'b1;
                    end
                    default:
                    begin
                        pin_oe_out[gi]    = 1'b0;
                    end
                endcase
                // peripheral sees nothing while the pin is claimed
                func_level_out[gi] = func_sel_out[gi] & level_r[gi];
            end
        end
    endgenerate

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_out_enable_match: assert property (
        (pin_oe_out & ~func_sel_out) == (pin_bus.mode & ~pin_bus.dir))
        else $error("output enable disagrees with mode and direction");
    a_out_drive_level: assert property (
        ((pin_drive_out ^ pin_bus.data) & pin_bus.mode & ~pin_bus.dir) == 0)
        else $error("output pin not driven with its data bit");
    a_normal_path_only: assert property (
        (((pin_oe_out ^ func_oe_in) & ~pin_bus.mode & ~pin_bus.dir) == 0)
        && ((func_level_out & ~func_sel_out) == 0))
        else $error("peripheral path leaks onto a claimed pin");
    a_pull_polarity: assert property (
        ((pull_down_out & ~PULL_DOWN_MASK) == 0) &&
        ((pull_up_out & PULL_DOWN_MASK) == 0) &&
        ((pull_up_out | pull_down_out) == (~pin_bus.mode & pin_bus.dir)))
        else $error("pull resistor wrong for pin setting");
    a_input_sync_level: assert property (
        (pin_level_in[0] == $past(pin_level_in[0]))[*5]
        |-> pin_bus.level[0] == pin_level_in[0])
        else $error("stable input not reflected after sync delay");

    c_pin_output: cover property (pin_oe_out[0] && !func_sel_out[0]);
    c_pin_pulldown: cover property (pull_down_out[1]);
endmodule

// [ppu_board.sv]
// Purpose: board side of the pins, resolves each pad wire
// Assumes: the unit's drive wins over any board driver
// Notes:   an undriven, unpulled wire toggles so no stale level survives
`timescale 1ns/1ps
module ppu_board
(
    input  wire logic             clk_in,
    input  wire ppu_pkg::ppu_pins_t drive_in,
    input  wire ppu_pkg::ppu_pins_t oe_in,
    input  wire ppu_pkg::ppu_pins_t pull_up_in,
    input  wire ppu_pkg::ppu_pins_t pull_down_in,
    input  wire ppu_pkg::ppu_pins_t ext_val_in,
    input  wire ppu_pkg::ppu_pins_t ext_en_in,
    output ppu_pkg::ppu_pins_t      level_out
);
    import ppu_pkg::*;
    ppu_pins_t noise_r = 32'h5555_AAAA;
    always @(posedge clk_in) noise_r <= ~noise_r;
    assign level_out = oe_in & drive_in | ~oe_in & (ext_en_in & ext_val_in
        | ~ext_en_in & (pull_up_in | ~pull_down_in & noise_r));
endmodule

// [ppu_top_bench.sv]
// Purpose: self-checking bench of the pin unit
// Assumes: bready and rready stay high, the unit answers within 50 cycles
// Notes:   drivers queue expected answers, a monitor compares them
`timescale 1ns/1ps
`include "ppu_cfg.svh"
module ppu_top_bench;
    import ppu_pkg::*;
    typedef struct {logic [31:0] d; logic [1:0] r;} ppu_exp_t;
    logic                   clk, rst, awv, wv, bry, arv, rry;
    logic                   awr, wr, bv, arr, rv;
    logic [`PPU_AXI_AW-1:0] awa, ara;
    logic [31:0]            wd, rd, v, s, m, dr, dt, ou, nf, fd, lv;
    logic [3:0]             ws;
    logic [1:0]             br, rr;
    ppu_pins_t              lvl, drv, oe, pu, pd, fo, foe, fsel, flvl, xv;
    ppu_exp_t               rq[$], e;
    logic [1:0]             bq[$];
    int                     err_total = 0, n_checks = 0, seed = 45, h, i;
    ppu_top ppu_top_i (.CORE_CLK_IN(clk), .RST_IN(rst),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
        .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr),
        .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .PIN_LEVEL_IN(lvl),
        .PIN_DRIVE_OUT(drv), .PIN_OE_OUT(oe), .PIN_PULL_UP_OUT(pu),
        .PIN_PULL_DOWN_OUT(pd), .FUNC_OUT_IN(fo), .FUNC_OE_IN(foe),
        .FUNC_SEL_OUT(fsel), .FUNC_LEVEL_OUT(flvl));
    ppu_board ppu_board_i (.clk_in(clk), .drive_in(drv), .oe_in(oe),
        .pull_up_in(pu), .pull_down_in(pd), .ext_val_in(xv),
        .ext_en_in(32'hFFFF_FFFF), .level_out(lvl));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // k picks mode, direction or data; h picks low or high half
    function automatic logic [11:0] ad(int k, int h);
        return `PPU_BYTE_ADDR(`PPU_IDX_MODE_LO + 12'(2 * k + 6 * h));
    endfunction
    function automatic logic [15:0] mrg(logic [15:0] o, n, logic [1:0] st);
        return {st[1] ? n[15:8] : o[15:8], st[0] ? n[7:0] : o[7:0]};
    endfunction
    // address and data go out together, each released once taken
    task automatic wr_reg(logic [11:0] a, logic [15:0] d, logic [3:0] st,
                          logic [1:0] er);
        logic ta, tw, tb;
        int   n;
        ta = 0;
        tw = 0;
        tb = 0;
        n = 0;
        bq.push_back(er);
        awa <= a;
        wd <= {16'h0000, d};
        ws <= st;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!tb && n < 50)
        begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wr;
            tb = bv;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            n++;
        end
        if (!tb)
        begin
            err_total++;
            end_sim;
        end
    endtask
    task automatic rd_reg(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
        logic ta, tr;
        int   n;
        ta = 0;
        tr = 0;
        n = 0;
        rq.push_back('{ed, er});
        ara <= a;
        arv <= 1'b1;
        while (!tr && n < 50)
        begin
            @(negedge clk);
            ta = arv && arr;
            tr = rv;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            n++;
        end
        if (!tr)
        begin
            err_total++;
            end_sim;
        end
    endtask
    // sampled mid-cycle, the handshake completes at the next rising edge
    always @(negedge clk)
    begin
        if (bv === 1'b1 && bq.size() > 0)
            chk("bresp", {30'h0, br}, {30'h0, bq.pop_front()});
        if (rv === 1'b1 && rq.size() > 0)
        begin
            e = rq.pop_front();
            chk("rdata", rd, e.d);
            chk("rresp", {30'h0, rr}, {30'h0, e.r});
        end
    end
    initial
    begin
        rst = 1'b1;
        {awv, wv, arv, awa, ara, wd, ws, fo, foe, xv} = '0;
        {bry, rry} = 2'b11;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("func_sel", fsel, 32'h0000_03F0);
        chk("pull_down", pd, 32'h0000_0402);
        chk("pull_up", pu, 32'hFFFF_F80D);
        @(posedge clk);
        rd_reg(ad(0, 0), 32'h0, `PPU_RESP_OKAY);
        rd_reg(ad(1, 0), 32'hFC0F, `PPU_RESP_OKAY);
        rd_reg(ad(0, 1), 32'h0, `PPU_RESP_OKAY);
        rd_reg(ad(1, 1), 32'hFFFF, `PPU_RESP_OKAY);
        wr_reg(12'h1C4, 16'h0000, 4'hF, `PPU_RESP_SLVERR);
        rd_reg(12'h1C4, 32'h0, `PPU_RESP_SLVERR);
        rd_reg(ad(1, 0), 32'hFC0F, `PPU_RESP_OKAY);
        m = 32'h0;
        dr = 32'hFFFF_FC0F;
        for (i = 0; i < 24; i++)
        begin
            fo <= $random(seed);
            foe <= $random(seed);
            xv <= $random(seed);
            for (h = 0; h < 2; h++)
            begin
                s = $random(seed);
                v = $random(seed);
                wr_reg(ad(0, h), v[15:0], {2'b00, s[1:0]}, 2'h0);
                m[16*h +: 16] = mrg(m[16*h +: 16], v[15:0], s[1:0]);
                v = $random(seed);
                wr_reg(ad(1, h), v[15:0], {2'b00, s[3:2]}, 2'h0);
                dr[16*h +: 16] = mrg(dr[16*h +: 16], v[15:0], s[3:2]);
                v = $random(seed);
                wr_reg(ad(2, h), v[15:0], s[7:4] | 4'h3, 2'h0);
                dt[16*h +: 16] = v[15:0];
            end
            // the level path runs through a synchroniser, let it settle
            repeat (6) @(posedge clk);
            @(negedge clk);
            ou = m & ~dr;
            nf = ~m & ~dr;
            fd = nf & foe;
            lv = fd & fo | ~fd & xv;
            chk("pin_oe", oe, ou | fd);
            chk("pin_drive", drv & oe, ou & dt | fd & fo);
            chk("pull_up", pu, ~m & dr & ~`PPU_PULL_DOWN_MASK);
            chk("pull_down", pd, ~m & dr & `PPU_PULL_DOWN_MASK);
            chk("func_sel", fsel, nf);
            chk("func_level", flvl, nf & lv);
            @(posedge clk);
            v = ou & dt | ~ou & lv;
            for (h = 0; h < 2; h++)
            begin
                rd_reg(ad(0, h), {16'h0, m[16*h +: 16]}, 2'h0);
                rd_reg(ad(1, h), {16'h0, dr[16*h +: 16]}, 2'h0);
                rd_reg(ad(2, h), {16'h0, v[16*h +: 16]}, 2'h0);
            end
        end
        // open drain: data held at zero, only direction moves the pins
        wr_reg(ad(0, 0), 16'hFFFF, 4'h3, 2'h0);
        wr_reg(ad(2, 0), 16'h0000, 4'h3, 2'h0);
        for (i = 0; i < 2; i++)
        begin
            v = (i == 0) ? $random(seed) : ~v;
            wr_reg(ad(1, 0), v[15:0], 4'h3, 2'h0);
            @(negedge clk);
            chk("od_oe", {16'h0, oe[15:0]}, {16'h0, ~v[15:0]});
            chk("od_drive", {16'h0, drv[15:0] & oe[15:0]}, 32'h0);
            @(posedge clk);
        end
        end_sim;
    end
endmodule
